// >>> ecc_irq_pkg.sv
// Constants, layouts and state types of the ECC error-reporting block.
`default_nettype none
package ecc_irq_pkg;
	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int PORTS = 2;
	localparam int LUT_DEPTH = 4;
	localparam int LANES = 8;
	localparam int MEM_AW = 16;
	localparam int AXI_AW = 8;
	localparam int CNT_W = 32;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_EN = 8'h00;
	localparam logic [7:0] OFS_EN_RST = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_MSTAT = 8'h0C;
	localparam logic [7:0] OFS_ISTAT = 8'h10;
	localparam logic [7:0] OFS_TEST = 8'h14;
	localparam logic [7:0] OFS_THR = 8'h18;
	localparam logic [7:0] OFS_CNT_CLR = 8'h1C;
	localparam logic [7:0] OFS_LANE = 8'h20;
	localparam logic [7:0] OFS_SADDR0 = 8'h24;
	localparam logic [7:0] OFS_SADDR1 = 8'h28;
	localparam logic [7:0] OFS_DADDR0 = 8'h2C;
	localparam logic [7:0] OFS_DADDR1 = 8'h30;
	localparam logic [7:0] OFS_CNT0 = 8'h34;
	localparam logic [7:0] OFS_CNT1 = 8'h38;
	localparam logic [7:0] OFS_LUT = 8'h40;
	localparam logic [7:0] OFS_LUT_END = 8'h60;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int EN_BIT = 0;
	localparam int MODE_BIT = 0;
	localparam int OVF_BIT = 1;
	localparam int CMP_BIT = 2;
	localparam int CMPF_LSB = 0;
	localparam int RMWS_LSB = 2;
	localparam int RMWD_LSB = 4;
	localparam int SPEND_LSB = 0;
	localparam int DPEND_LSB = 2;
	localparam int TST_S_BIT = 0;
	localparam int TST_D_BIT = 1;
	localparam int VALID_BIT = 31;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic single_err;
		logic double_err;
		logic rmw;
		logic [LANES-1:0] lanes;
		logic [MEM_AW-1:0] addr;
	} err_event_type;

	typedef struct packed {
		logic [PORTS-1:0] single_irq;
		logic double_irq;
	} irq_out_type;

	typedef struct packed {
		logic awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_AW-1:0] araddr;
		logic rready;
	} axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_resp_type;

	typedef struct packed {
		logic aw_full;
		logic [AXI_AW-1:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic sbe_en;
		logic mode;
		logic on_ovf;
		logic on_cmp;
		logic [CNT_W-1:0] thr;
		logic [PORTS-1:0] sing_pend;
		logic [PORTS-1:0] dbl_pend;
		logic [PORTS-1:0] cmp_flag;
		logic [PORTS-1:0] rmw_s;
		logic [PORTS-1:0] rmw_d;
		logic [LANES-1:0] lanes;
		logic [PORTS-1:0][MEM_AW-1:0] saddr;
		logic [PORTS-1:0][MEM_AW-1:0] daddr;
		logic [PORTS-1:0][CNT_W-1:0] cnt;
		logic [PORTS-1:0][LUT_DEPTH-1:0] lut_v;
		logic [PORTS-1:0][LUT_DEPTH-1:0][MEM_AW-1:0] lut_a;
	} state_type;

	localparam state_type STATE_RST = '0;
endpackage : ecc_irq_pkg
`default_nettype wire

// >>> ecc_error_irq.sv
// ECC single- and double-bit error reporting with an AXI4-Lite register file.
// Notes on behaviour
// - Separate single and double error requests out.
// - Dual-port memory: one single request per port.
// - Single request per selected cause only.
// - Log latest single error address per port while single enable is set.
// - Flag errors during partial-write read-modify-write.
// - Writing single pending bit clears single requests.
// - Enable-reset write disables single interrupts.
// - Per-lane decoder single-error status register.
// - Mode zero: interrupt on every single error.
// - Table logs new addresses only, with valid.
// - Table records nothing while mode bit zero.
// - Mode one, no overflow: interrupt per entry.
// - Overflow mode: interrupt on full-table new address.
// - Compare mode counts single errors independently while its flag is clear and the count is below threshold.
// - Count at threshold raises request, flag, pending.
// - Counter frozen while compare flag is set.
// - Counter clear zeroes count; flag clears separately.
// - Raised threshold: counting resumes from kept value.
// - Double error always interrupts and logs address.
// - Double request holds until its pending written.
// - Test bits assert requests, cleared by pending.
// - Thirty-two bit counters share one threshold.
// - Entry top bit is valid, write-one clears.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ecc_error_irq (
	input wire logic clk,
	input wire logic rst_b,
	input wire ecc_irq_pkg::axi_req_type axi_i,
	output ecc_irq_pkg::axi_resp_type axi_o,
	input wire ecc_irq_pkg::err_event_type [ecc_irq_pkg::PORTS-1:0] err_i,
	output ecc_irq_pkg::irq_out_type irq_o
);
	ecc_irq_pkg::state_type s_q;
	ecc_irq_pkg::state_type s_d;
	logic wr_now;
	logic [ecc_irq_pkg::AXI_AW-1:0] wa;
	logic [31:0] wd;

	// ------------------------------------------------------------------
	// Register read decode
	// ------------------------------------------------------------------
	// Bit 32 of the result tells whether the address is mapped.
	function automatic logic [32:0] reg_read(
		input ecc_irq_pkg::state_type s,
		input logic [ecc_irq_pkg::AXI_AW-1:0] a
	);
		logic [32:0] r;
		logic [2:0] idx;
		r = {1'b1, 32'h0000_0000};
		idx = 3'((a - ecc_irq_pkg::OFS_LUT) >> 2);
		case (a)
			ecc_irq_pkg::OFS_EN: r[0] = s.sbe_en;
			ecc_irq_pkg::OFS_EN_RST: r[0] = 1'b0;
			ecc_irq_pkg::OFS_MODE: r[2:0] = {s.on_cmp, s.on_ovf, s.mode};
			ecc_irq_pkg::OFS_MSTAT: r[5:0] = {s.rmw_d, s.rmw_s, s.cmp_flag};
			ecc_irq_pkg::OFS_ISTAT: r[3:0] = {s.dbl_pend, s.sing_pend};
			ecc_irq_pkg::OFS_TEST: r[0] = 1'b0;
			ecc_irq_pkg::OFS_THR: r[31:0] = s.thr;
			ecc_irq_pkg::OFS_CNT_CLR: r[0] = 1'b0;
			ecc_irq_pkg::OFS_LANE: r[7:0] = s.lanes;
			ecc_irq_pkg::OFS_SADDR0: r[15:0] = s.saddr[0];
			ecc_irq_pkg::OFS_SADDR1: r[15:0] = s.saddr[1];
			ecc_irq_pkg::OFS_DADDR0: r[15:0] = s.daddr[0];
			ecc_irq_pkg::OFS_DADDR1: r[15:0] = s.daddr[1];
			ecc_irq_pkg::OFS_CNT0: r[31:0] = s.cnt[0];
			ecc_irq_pkg::OFS_CNT1: r[31:0] = s.cnt[1];
			default: begin
				if (a >= ecc_irq_pkg::OFS_LUT && a < ecc_irq_pkg::OFS_LUT_END
						&& a[1:0] == 2'h0) begin
					r[ecc_irq_pkg::VALID_BIT] = s.lut_v[idx[2]][idx[1:0]];
					r[15:0] = s.lut_a[idx[2]][idx[1:0]];
				end else begin
					r[32] = 1'b0;
				end
			end
		endcase
		return r;
	endfunction : reg_read

	// ------------------------------------------------------------------
	// Bus slave outputs
	// ------------------------------------------------------------------
	assign wr_now = s_q.aw_full && s_q.w_full && !s_q.bvalid;
	assign wa = s_q.aw_addr;
	assign wd = s_q.w_data & {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
		{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};

	assign axi_o.awready = !s_q.aw_full;
	assign axi_o.wready = !s_q.w_full;
	assign axi_o.bvalid = s_q.bvalid;
	assign axi_o.bresp = s_q.bresp;
	assign axi_o.arready = !s_q.rvalid;
	assign axi_o.rvalid = s_q.rvalid;
	assign axi_o.rdata = s_q.rdata;
	assign axi_o.rresp = s_q.rresp;

	assign irq_o.single_irq = s_q.sing_pend;
	assign irq_o.double_irq = |s_q.dbl_pend;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [32:0] rr;
		logic wsel;
		logic hit;
		logic full;
		logic placed;
		logic newu;
		logic match;
		logic inc;
		logic sev;
		logic [31:0] m;
		s_d = s_q;
		rr = 33'h0_0000_0000;
		wsel = 1'b0;
		hit = 1'b0;
		full = 1'b0;
		placed = 1'b0;
		newu = 1'b0;
		match = 1'b0;
		inc = 1'b0;
		sev = 1'b0;
		m = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
			{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};

		// Write channels are held until both halves are present.
		if (axi_i.awvalid && !s_q.aw_full) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = axi_i.awaddr;
		end
		if (axi_i.wvalid && !s_q.w_full) begin
			s_d.w_full = 1'b1;
			s_d.w_data = axi_i.wdata;
			s_d.w_strb = axi_i.wstrb;
		end
		if (s_q.bvalid && axi_i.bready) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_now) begin
			rr = reg_read(s_q, wa);
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = rr[32] ? ecc_irq_pkg::RESP_OKAY
				: ecc_irq_pkg::RESP_SLVERR;
		end
		if (s_q.rvalid && axi_i.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_i.arvalid && !s_q.rvalid) begin
			rr = reg_read(s_q, axi_i.araddr);
			s_d.rvalid = 1'b1;
			s_d.rdata = rr[31:0];
			s_d.rresp = rr[32] ? ecc_irq_pkg::RESP_OKAY
				: ecc_irq_pkg::RESP_SLVERR;
		end

		// Plain control writes.
		if (wr_now) begin
			case (wa)
				ecc_irq_pkg::OFS_EN: begin
					if (wd[ecc_irq_pkg::EN_BIT]) begin
						s_d.sbe_en = 1'b1;
					end
				end
				ecc_irq_pkg::OFS_EN_RST: begin
					if (wd[ecc_irq_pkg::EN_BIT]) begin
						s_d.sbe_en = 1'b0;
					end
				end
				ecc_irq_pkg::OFS_MODE: begin
					if (s_q.w_strb[0]) begin
						s_d.mode = wd[ecc_irq_pkg::MODE_BIT];
						s_d.on_ovf = wd[ecc_irq_pkg::OVF_BIT];
						s_d.on_cmp = wd[ecc_irq_pkg::CMP_BIT];
					end
				end
				ecc_irq_pkg::OFS_THR: s_d.thr = (s_q.thr & ~m) | wd;
				default: s_d.thr = s_q.thr;
			endcase
		end

		// Write-one-to-clear first; hardware sets below win over them.
		wsel = wr_now && wa == ecc_irq_pkg::OFS_LANE;
		s_d.lanes = s_q.lanes & ~(wsel ? wd[7:0] : 8'h00);
		for (int p = 0; p < ecc_irq_pkg::PORTS; p++) begin
			wsel = wr_now && wa == ecc_irq_pkg::OFS_ISTAT;
			if (wsel && wd[ecc_irq_pkg::SPEND_LSB + p]) begin
				s_d.sing_pend[p] = 1'b0;
			end
			if (wsel && wd[ecc_irq_pkg::DPEND_LSB + p]) begin
				s_d.dbl_pend[p] = 1'b0;
			end
			wsel = wr_now && wa == ecc_irq_pkg::OFS_MSTAT;
			if (wsel && wd[ecc_irq_pkg::CMPF_LSB + p]) begin
				s_d.cmp_flag[p] = 1'b0;
			end
			if (wsel && wd[ecc_irq_pkg::RMWS_LSB + p]) begin
				s_d.rmw_s[p] = 1'b0;
			end
			if (wsel && wd[ecc_irq_pkg::RMWD_LSB + p]) begin
				s_d.rmw_d[p] = 1'b0;
			end
			for (int e = 0; e < ecc_irq_pkg::LUT_DEPTH; e++) begin
				if (wr_now && wd[ecc_irq_pkg::VALID_BIT] && wa ==
						ecc_irq_pkg::OFS_LUT
						+ 8'(4 * (p * ecc_irq_pkg::LUT_DEPTH + e))) begin
					s_d.lut_v[p][e] = 1'b0;
				end
			end

			// Address table search over the entries as they stood.
			hit = 1'b0;
			full = 1'b1;
			for (int e = 0; e < ecc_irq_pkg::LUT_DEPTH; e++) begin
				if (s_q.lut_v[p][e] && s_q.lut_a[p][e] == err_i[p].addr) begin
					hit = 1'b1;
				end
				full = full & s_q.lut_v[p][e];
			end
			newu = err_i[p].single_err && s_q.mode && !hit;
			placed = 1'b0;
			for (int e = 0; e < ecc_irq_pkg::LUT_DEPTH; e++) begin
				if (newu && !placed && !s_q.lut_v[p][e]) begin
					s_d.lut_v[p][e] = 1'b1;
					s_d.lut_a[p][e] = err_i[p].addr;
					placed = 1'b1;
				end
			end

			// Counter compares before counting, so a match freezes it.
			match = s_q.on_cmp && !s_q.cmp_flag[p]
				&& s_q.cnt[p] >= s_q.thr;
			inc = s_q.on_cmp && err_i[p].single_err
				&& !s_q.cmp_flag[p] && !match;
			if (wr_now && wa == ecc_irq_pkg::OFS_CNT_CLR && wd[p]) begin
				s_d.cnt[p] = ecc_irq_pkg::CNT_ZERO;
			end else if (inc) begin
				s_d.cnt[p] = s_q.cnt[p] + ecc_irq_pkg::CNT_ONE;
			end
			if (match) begin
				s_d.cmp_flag[p] = 1'b1;
			end

			// Single-bit request causes, each under its own mode.
			sev = err_i[p].single_err && (!s_q.mode
				|| (newu && (s_q.on_ovf ? full : !full)));
			if (s_q.sbe_en && (sev || match)) begin
				s_d.sing_pend[p] = 1'b1;
			end
			if (wr_now && wa == ecc_irq_pkg::OFS_TEST
					&& wd[ecc_irq_pkg::TST_S_BIT]) begin
				s_d.sing_pend[p] = 1'b1;
			end
			if (wr_now && wa == ecc_irq_pkg::OFS_TEST
					&& wd[ecc_irq_pkg::TST_D_BIT]) begin
				s_d.dbl_pend[p] = 1'b1;
			end
			if (s_q.sbe_en && err_i[p].single_err) begin
				s_d.saddr[p] = err_i[p].addr;
			end
			if (err_i[p].single_err) begin
				s_d.lanes = s_d.lanes | err_i[p].lanes;
				s_d.rmw_s[p] = s_d.rmw_s[p] | err_i[p].rmw;
			end
			if (err_i[p].double_err) begin
				s_d.dbl_pend[p] = 1'b1;
				s_d.daddr[p] = err_i[p].addr;
				s_d.rmw_d[p] = s_d.rmw_d[p] | err_i[p].rmw;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_q <= ecc_irq_pkg::STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	all_mode_irq_a: assert property (
		!s_q.mode && s_q.sbe_en && err_i[0].single_err
		|=> irq_o.single_irq[0])
		else $error("single error in mode zero gave no request");
	table_idle_a: assert property (
		!s_q.mode && !wr_now
		|=> (s_q.lut_v[0] & ~$past(s_q.lut_v[0])) == 4'h0)
		else $error("table logged an entry with mode bit clear");
	ovf_only_a: assert property (
		s_q.mode && s_q.on_ovf && !s_q.on_cmp && !(&s_q.lut_v[0])
		&& !irq_o.single_irq[0] && !wr_now
		|=> !irq_o.single_irq[0])
		else $error("overflow mode raised request without overflow");
	cnt_frozen_a: assert property (
		s_q.cmp_flag[0] && !wr_now |=> $stable(s_q.cnt[0]))
		else $error("counter moved while compare flag set");
	cnt_clear_a: assert property (
		wr_now && wa == ecc_irq_pkg::OFS_CNT_CLR && wd[0]
		|=> s_q.cnt[0] == ecc_irq_pkg::CNT_ZERO)
		else $error("counter clear did not zero counter");
	dbl_log_a: assert property (
		err_i[1].double_err
		|=> irq_o.double_irq && s_q.daddr[1] == $past(err_i[1].addr))
		else $error("double error not raised or not logged");
	en_reset_a: assert property (
		wr_now && wa == ecc_irq_pkg::OFS_EN_RST && wd[0] |=> !s_q.sbe_en)
		else $error("enable reset write left enable set");
	test_irq_a: assert property (
		wr_now && wa == ecc_irq_pkg::OFS_TEST && wd[1]
		|=> irq_o.double_irq ##1 irq_o.double_irq || wr_now)
		else $error("double test bit gave no held request");
	pend_hold_a: assert property (
		irq_o.single_irq[0] && !(wr_now && wa == ecc_irq_pkg::OFS_ISTAT)
		|=> irq_o.single_irq[0])
		else $error("single request dropped without clear write");
	match_flag_a: assert property (
		s_q.on_cmp && !s_q.cmp_flag[0] && s_q.cnt[0] >= s_q.thr
		|=> s_q.cmp_flag[0] && (irq_o.single_irq[0] || !$past(s_q.sbe_en)))
		else $error("threshold reached without flag and request");
	dbl_hold_a: assert property (
		irq_o.double_irq && !(wr_now && wa == ecc_irq_pkg::OFS_ISTAT)
		|=> irq_o.double_irq)
		else $error("double request dropped without clear write");
	sing_clear_a: assert property (
		wr_now && wa == ecc_irq_pkg::OFS_ISTAT
		&& wd[ecc_irq_pkg::SPEND_LSB] && !err_i[0].single_err && !s_q.on_cmp
		|=> !irq_o.single_irq[0])
		else $error("pending write did not clear single request");
	saddr_log_a: assert property (
		s_q.sbe_en && err_i[0].single_err
		|=> s_q.saddr[0] == $past(err_i[0].addr))
		else $error("single error address not logged");
	port_single_a: assert property (
		!s_q.mode && s_q.sbe_en && err_i[1].single_err
		|=> irq_o.single_irq[1])
		else $error("second port single error gave no request");
	new_entry_a: assert property (
		s_q.mode && !s_q.on_ovf && s_q.sbe_en && !wr_now
		|=> s_q.lut_v[0] == $past(s_q.lut_v[0]) || irq_o.single_irq[0])
		else $error("new table entry raised no request");
	no_relog_a: assert property (
		s_q.mode && err_i[0].single_err && !wr_now && s_q.lut_v[0][0]
		&& s_q.lut_a[0][0] == err_i[0].addr
		|=> s_q.lut_v[0] == $past(s_q.lut_v[0]))
		else $error("repeated address logged again");
	rmw_single_a: assert property (
		err_i[1].single_err && err_i[1].rmw |=> s_q.rmw_s[1])
		else $error("single error in partial write not flagged");
	rmw_double_a: assert property (
		err_i[1].double_err && err_i[1].rmw |=> s_q.rmw_d[1])
		else $error("double error in partial write not flagged");
	lane_log_a: assert property (
		err_i[1].single_err
		|=> (s_q.lanes & $past(err_i[1].lanes)) == $past(err_i[1].lanes))
		else $error("decoder lanes of single error not recorded");

	dbl_seen_c: cover property (irq_o.double_irq);
	test_seen_c: cover property (wr_now && wa == ecc_irq_pkg::OFS_TEST);
	cmp_seen_c: cover property ($rose(s_q.cmp_flag[0]));
	ovf_seen_c: cover property (&s_q.lut_v[0] && s_q.on_ovf
		&& $rose(irq_o.single_irq[0]));
endmodule : ecc_error_irq
`default_nettype wire

// >>> irq_aggregator.sv
// System-manager side model that counts forwarded double-error requests.
`timescale 1ns/1ps
`default_nettype none
module irq_aggregator (
	input wire logic clk,
	input wire logic rst_b,
	input wire ecc_irq_pkg::irq_out_type irq_i,
	output logic [7:0] dbl_rises
);
	logic last_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_q <= 1'b0;
			dbl_rises <= 8'h00;
		end else begin
			last_q <= irq_i.double_irq;
			if (irq_i.double_irq && !last_q) begin
				dbl_rises <= dbl_rises + 8'h01;
			end
		end
	end
endmodule : irq_aggregator
`default_nettype wire

// >>> ecc_error_interrupt_logic_bench.sv
// Self-checking bench for the ECC error-reporting block.
`timescale 1ns/1ps
`default_nettype none
module ecc_error_interrupt_logic_bench;
	logic clk;
	logic rst_b;
	ecc_irq_pkg::axi_req_type q;
	ecc_irq_pkg::axi_resp_type r;
	ecc_irq_pkg::err_event_type [1:0] ev;
	ecc_irq_pkg::irq_out_type irq;
	logic [7:0] dbl_rises;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [15:0] a;
	logic [15:0] lut_m[$];
	logic hit;
	logic nw;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int cnt_m;
	int thr_m;
	bit flag_m;

	ecc_error_irq uut (.clk(clk), .rst_b(rst_b), .axi_i(q), .axi_o(r),
		.err_i(ev), .irq_o(irq));
	irq_aggregator agg (.clk(clk), .rst_b(rst_b), .irq_i(irq),
		.dbl_rises(dbl_rises));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic finish_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wr(logic [7:0] ad, logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		q.awvalid <= 1'b1;
		q.awaddr <= ad;
		q.wvalid <= 1'b1;
		q.wdata <= d;
		q.wstrb <= 4'hf;
		q.bready <= 1'b1;
		// Each channel is released at the edge that takes it.
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && r.awready === 1'b1) begin
				aw_done = 1'b1;
				q.awvalid <= 1'b0;
			end
			if (!w_done && r.wready === 1'b1) begin
				w_done = 1'b1;
				q.wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (r.bvalid !== 1'b1);
		rsp = r.bresp;
		q.bready <= 1'b0;
	endtask : wr

	task automatic rdr(logic [7:0] ad);
		@(posedge clk);
		q.arvalid <= 1'b1;
		q.araddr <= ad;
		q.rready <= 1'b1;
		do @(posedge clk); while (r.arready !== 1'b1);
		q.arvalid <= 1'b0;
		do @(posedge clk); while (r.rvalid !== 1'b1);
		rd = r.rdata;
		rsp = r.rresp;
		q.rready <= 1'b0;
	endtask : rdr

	task automatic rc(logic [7:0] ad, logic [31:0] e);
		rdr(ad);
		chk($sformatf("reg %h", ad), rd, e);
	endtask : rc

	task automatic ci(logic [2:0] e);
		@(negedge clk);
		chk("irq", 32'(irq), 32'(e));
	endtask : ci

	// Kind is single, double, read-modify-write from high to low.
	task automatic er(int p, logic [2:0] k, logic [7:0] ln, logic [15:0] ad);
		@(posedge clk);
		ev[p] <= {k, ln, ad};
		@(posedge clk);
		ev[p] <= '0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : er

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test;
		end
	end

	initial begin
		rst_b = 1'b0;
		q = '0;
		ev = '0;
		cnt_m = 0;
		flag_m = 1'b0;
		a = 16'($urandom(32'h0000_c67f));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		ci(3'h0);
		rc(ecc_irq_pkg::OFS_EN, 32'h0000_0000);
		chk("rresp", 32'(rsp), 32'(ecc_irq_pkg::RESP_OKAY));
		// Mode zero raises a request for every single error while single enable is set.
		wr(ecc_irq_pkg::OFS_EN, 32'h0000_0001);
		er(0, 3'h4, 8'h00, a);
		ci(3'h2);
		rc(ecc_irq_pkg::OFS_SADDR0, {16'h0000, a});
		rc(ecc_irq_pkg::OFS_LUT, 32'h0000_0000);
		wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0000);
		ci(3'h2);
		wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0001);
		ci(3'h0);
		er(0, 3'h4, 8'h00, a);
		er(1, 3'h5, 8'h5a, ~a);
		ci(3'h6);
		rc(ecc_irq_pkg::OFS_LANE, 32'h0000_005a);
		er(1, 3'h3, 8'h00, a ^ 16'h00ff);
		ci(3'h7);
		rc(ecc_irq_pkg::OFS_DADDR1, {16'h0000, a ^ 16'h00ff});
		rc(ecc_irq_pkg::OFS_MSTAT, 32'h0000_0028);
		wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0003);
		ci(3'h1);
		wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0008);
		ci(3'h0);
		wr(ecc_irq_pkg::OFS_MSTAT, 32'h0000_003c);
		wr(ecc_irq_pkg::OFS_EN_RST, 32'h0000_0001);
		chk("bresp", 32'(rsp), 32'(ecc_irq_pkg::RESP_OKAY));
		er(0, 3'h4, 8'h00, a);
		ci(3'h0);
		wr(ecc_irq_pkg::OFS_EN, 32'h0000_0001);
		// Table mode: a request per new entry, nothing once full.
		wr(ecc_irq_pkg::OFS_MODE, 32'h0000_0001);
		for (int k = 0; k < 6; k++) begin
			a = (k == 2) ? lut_m[0] : 16'($urandom);
			hit = 1'b0;
			foreach (lut_m[j]) if (lut_m[j] === a) hit = 1'b1;
			nw = !hit && (lut_m.size() < 4);
			er(0, 3'h4, 8'h00, a);
			ci({1'b0, nw, 1'b0});
			if (nw) lut_m.push_back(a);
			wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0001);
		end
		for (int j = 0; j < 4; j++) begin
			rc(ecc_irq_pkg::OFS_LUT + 8'(4 * j), {16'h8000, lut_m[j]});
		end
		wr(ecc_irq_pkg::OFS_LUT, 32'h8000_0000);
		rdr(ecc_irq_pkg::OFS_LUT);
		chk("valid", 32'(rd[31]), 32'h0000_0000);
		wr(ecc_irq_pkg::OFS_MODE, 32'h0000_0003);
		er(0, 3'h4, 8'h00, ~lut_m[1]);
		ci(3'h0);
		er(0, 3'h4, 8'h00, ~lut_m[2]);
		ci(3'h2);
		// Threshold compare on repeats of a logged address.
		wr(ecc_irq_pkg::OFS_CNT_CLR, 32'h0000_0003);
		wr(ecc_irq_pkg::OFS_THR, 32'h0000_0002);
		wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0003);
		wr(ecc_irq_pkg::OFS_MODE, 32'h0000_0007);
		a = lut_m[1];
		thr_m = 2;
		for (int k = 1; k <= 6; k++) begin
			er(0, 3'h4, 8'h00, a);
			if (!flag_m) cnt_m++;
			if (cnt_m >= thr_m) flag_m = 1'b1;
			rc(ecc_irq_pkg::OFS_CNT0, cnt_m);
			rc(ecc_irq_pkg::OFS_MSTAT, 32'(flag_m));
			ci({1'b0, flag_m, 1'b0});
			if (k == 3) begin
				thr_m = 4;
				wr(ecc_irq_pkg::OFS_THR, 32'h0000_0004);
			end else if (k == 5) begin
				cnt_m = 0;
				wr(ecc_irq_pkg::OFS_CNT_CLR, 32'h0000_0001);
				rc(ecc_irq_pkg::OFS_CNT0, 32'h0000_0000);
			end
			if (k == 3 || k == 5) begin
				rc(ecc_irq_pkg::OFS_MSTAT, 32'h0000_0001);
				wr(ecc_irq_pkg::OFS_MSTAT, 32'h0000_0001);
				wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_0001);
				flag_m = 1'b0;
			end
		end
		// Interrupt self-test and a refused address.
		wr(ecc_irq_pkg::OFS_TEST, 32'h0000_0002);
		ci(3'h1);
		wr(ecc_irq_pkg::OFS_TEST, 32'h0000_0001);
		ci(3'h7);
		wr(ecc_irq_pkg::OFS_ISTAT, 32'h0000_000f);
		ci(3'h0);
		wr(8'h3c, 32'hffff_ffff);
		chk("bresp", 32'(rsp), 32'(ecc_irq_pkg::RESP_SLVERR));
		ci(3'h0);
		rc(8'h64, 32'h0000_0000);
		chk("rresp", 32'(rsp), 32'(ecc_irq_pkg::RESP_SLVERR));
		chk("rises", 32'(dbl_rises), 32'h0000_0002);
		finish_test;
	end
endmodule : ecc_error_interrupt_logic_bench
`default_nettype wire
